// [design/gpx_port.sv]
// eight-pin gpio port with external interrupt and alternate functions
//
// Overview of operation
// - direction bit zero makes pin an input
// - input pin read returns present pin level
// - data write to input only updates latch
// - each interrupt input pin can request independently
// - sensitivity register selects triggering event type
// - pins qualified by sensitivity, then ORed together
// - pending latch unreadable, cleared on vector fetch
// - writing sensitivity cancels pending request
// - direction bit one selects output from latch
// - push-pull drives both levels, open-drain releases high
// - output option zero open-drain, one push-pull
// - input option zero floating, one pull-up/interrupt
// - claiming peripheral overrides direction and option for pin drive and pull-up
// - peripheral output forces output with its drive
// - input pin with alternate output reads that
// - output pin feeds latch to peripheral input
// - low-power modes keep port; interrupt wakes device
// - interrupt needs input-with-interrupt and mask inactive
`timescale 1ns/10ps
`default_nettype none

`include "gpx_cfg.svh"

module gpx_port
  import gpx_pkg::*;
#(
  parameter logic [7:0] IRQ_PINS = `GPX_IRQ_PINS_DEF,
  parameter logic [7:0] PULL_PINS = `GPX_PULL_PINS_DEF
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] pinIn,
  output logic [7:0] pinOut,
  output logic [7:0] pinOe,
  output logic [7:0] pullUpEn,
  input wire logic [7:0] altEnable,
  input wire logic [7:0] altOutEn,
  input wire logic [7:0] altOut,
  input wire logic [7:0] altOpenDrain,
  output logic [7:0] altIn,
  input wire logic cpuIrqMask,
  input wire logic vectorFetch,
  output logic irqReq,
  output logic wakeReq
);

  // ========================================================================
  // elaboration checks
  generate
    if ((IRQ_PINS & PULL_PINS) != 8'h00)
    begin : g_chk
      $error("gpx_port: a pin cannot be both pull-up and interrupt capable");
    end
  endgenerate

  // ========================================================================
  // state
  logic [7:0] latch_reg;
  logic [7:0] dir_reg;
  logic [7:0] cfg_reg;
  gpx_sense_type sense_reg;
  logic pending_reg;
  logic pending_next;
  logic [7:0] prevPin_reg;
  logic [7:0] pinOut_reg;
  logic [7:0] pinOe_reg;
  logic [7:0] pullUp_reg;
  logic [7:0] altIn_reg;
  logic irqReq_reg;
  logic wakeReq_reg;
  logic [11:0] addr_reg;
  logic wrPend_reg;
  logic rdPend_reg;
  logic hreadyout_reg;
  logic hreadyout_next;
  logic [31:0] hrdata_reg;
  logic [7:0] pinSync;

  gpx_sync #(
    .WIDTH(8)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .asyncIn(pinIn),
    .syncOut(pinSync)
  );

  // ========================================================================
  // ahb-lite slave decode
  // reads take one wait state so that a write in the previous data phase is
  // always visible; writes complete with no wait state
  wire addrTake = hsel & hready & htrans[1];
  wire wrWord = hwrite & (hsize == `GPX_HSIZE_WORD);
  wire hitData = (addr_reg == `GPX_OFF_DATA);
  wire hitDir = (addr_reg == `GPX_OFF_DIR);
  wire hitCfg = (addr_reg == `GPX_OFF_CFG);
  wire hitSense = (addr_reg == `GPX_OFF_SENSE);
  wire hitLevel = (addr_reg == `GPX_OFF_LEVEL);
  wire wrData = wrPend_reg & hitData;
  wire wrDir = wrPend_reg & hitDir;
  wire wrCfg = wrPend_reg & hitCfg;
  wire wrSense = wrPend_reg & hitSense;

  assign hreadyout_next = ~(addrTake & ~hwrite);

  // ========================================================================
  // pin configuration
  wire [7:0] altOwns = altEnable & altOutEn;
  wire [7:0] outMode = dir_reg | altOwns;
  wire [7:0] driveVal = (altOwns & altOut) | (~altOwns & latch_reg);
  wire [7:0] openDrain = (altOwns & altOpenDrain) | (~altOwns & ~cfg_reg);
  // open-drain only ever pulls low; a one releases the pin
  wire [7:0] oeNext = outMode & (~openDrain | ~driveVal);
  wire [7:0] pullNext = ~outMode & cfg_reg & PULL_PINS;
  wire [7:0] altInNext = (dir_reg & latch_reg) | (~dir_reg & pinSync);

  // data register view: latch for outputs, peripheral output or pin otherwise
  wire [7:0] inputView = (altOwns & altOut) | (~altOwns & pinSync);
  wire [7:0] dataView = (dir_reg & latch_reg) | (~dir_reg & inputView);

  wire [31:0] rdWord = hitData ? {24'h000000, dataView} :
                       hitDir ? {24'h000000, dir_reg} :
                       hitCfg ? {24'h000000, cfg_reg} :
                       hitSense ? {30'h00000000, sense_reg} :
                       hitLevel ? {24'h000000, pinSync} :
                       `GPX_RST_WORD;

  // ========================================================================
  // external interrupt detection
  wire [7:0] riseEv = pinSync & ~prevPin_reg;
  wire [7:0] fallEv = ~pinSync & prevPin_reg;
  wire [7:0] senseHit = (sense_reg == GPX_SENSE_LOW) ? ~pinSync :
                        (sense_reg == GPX_SENSE_RISE) ? riseEv :
                        (sense_reg == GPX_SENSE_FALL) ? fallEv :
                        (riseEv | fallEv);
  wire [7:0] irqEnable = ~dir_reg & cfg_reg & IRQ_PINS;
  wire eventAny = |(senseHit & irqEnable);

  // a new event wins over a vector fetch or sensitivity write in the same cycle
  assign pending_next = eventAny | (pending_reg & ~vectorFetch & ~wrSense);

  // ========================================================================
  // bus registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      addr_reg <= 12'h000;
      wrPend_reg <= 1'b0;
      rdPend_reg <= 1'b0;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= `GPX_RST_WORD;
    end
    else
    begin
      if (addrTake)
      begin
        addr_reg <= haddr[11:0];
      end
      wrPend_reg <= addrTake & wrWord;
      rdPend_reg <= addrTake & ~hwrite;
      hreadyout_reg <= hreadyout_next;
      if (rdPend_reg)
      begin
        hrdata_reg <= rdWord;
      end
    end
  end

  // ========================================================================
  // port registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      latch_reg <= `GPX_RST_PORT;
      dir_reg <= `GPX_RST_PORT;
      cfg_reg <= `GPX_RST_PORT;
      sense_reg <= gpx_sense_type'(`GPX_RST_SENSE);
    end
    else
    begin
      if (wrData)
      begin
        latch_reg <= hwdata[7:0];
      end
      if (wrDir)
      begin
        dir_reg <= hwdata[7:0];
      end
      if (wrCfg)
      begin
        cfg_reg <= hwdata[7:0];
      end
      if (wrSense)
      begin
        sense_reg <= gpx_sense_type'(hwdata[1:0]);
      end
    end
  end

  // ========================================================================
  // pin drivers and interrupt request
  // no low-power input reaches this logic: wait and halt leave pins as set
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pinOut_reg <= 8'h00;
      pinOe_reg <= 8'h00;
      pullUp_reg <= 8'h00;
      altIn_reg <= 8'h00;
      prevPin_reg <= 8'h00;
      pending_reg <= 1'b0;
      irqReq_reg <= 1'b0;
      wakeReq_reg <= 1'b0;
    end
    else
    begin
      pinOut_reg <= driveVal;
      pinOe_reg <= oeNext;
      pullUp_reg <= pullNext;
      altIn_reg <= altInNext;
      prevPin_reg <= pinSync;
      pending_reg <= pending_next;
      irqReq_reg <= pending_next & ~cpuIrqMask;
      wakeReq_reg <= pending_next;
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign pinOut = pinOut_reg;
  assign pinOe = pinOe_reg;
  assign pullUpEn = pullUp_reg;
  assign altIn = altIn_reg;
  assign irqReq = irqReq_reg;
  assign wakeReq = wakeReq_reg;

  // ========================================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_inputHiZ;
    (outMode == 8'h00) |=> (pinOe == 8'h00);
  endproperty
  a_inputHiZ: assert property (p_inputHiZ)
    else $error("pin driven while every pin is an input");

  property p_readInput;
    (rdPend_reg && hitData && dir_reg == 8'h00 && altOwns == 8'h00)
      |=> (hrdata[7:0] == $past(pinSync)) ##1 hreadyout;
  endproperty
  a_readInput: assert property (p_readInput)
    else $error("input read did not return synchronised pin level");

  property p_latchWriteNoDrive;
    (wrData && dir_reg == 8'h00 && altOwns == 8'h00 && !wrDir)
      |=> (latch_reg == $past(hwdata[7:0])) ##1 (pinOe == 8'h00);
  endproperty
  a_latchWriteNoDrive: assert property (p_latchWriteNoDrive)
    else $error("latch write to input pins changed latch wrongly or drove pins");

  property p_eventPends;
    eventAny |=> pending_reg && wakeReq;
  endproperty
  a_eventPends: assert property (p_eventPends)
    else $error("qualified event did not set pending request");

  property p_fetchClears;
    (vectorFetch && pending_reg && !eventAny) |=> !pending_reg && !irqReq && !wakeReq;
  endproperty
  a_fetchClears: assert property (p_fetchClears)
    else $error("vector fetch did not clear pending request");

  property p_senseClears;
    (wrSense && !eventAny) |=> !pending_reg && !wakeReq;
  endproperty
  a_senseClears: assert property (p_senseClears)
    else $error("sensitivity write did not cancel pending request");

  property p_maskGates;
    irqReq |-> $past(pending_next) && !$past(cpuIrqMask);
  endproperty
  a_maskGates: assert property (p_maskGates)
    else $error("interrupt raised while masked or not pending");

  property p_openDrainRelease;
    1'b1 |=> ((pinOe & $past(outMode & openDrain & driveVal)) == 8'h00);
  endproperty
  a_openDrainRelease: assert property (p_openDrainRelease)
    else $error("open-drain pin drove a high level");

  property p_altPushPull;
    1'b1 |=> ((pinOe & $past(altOwns & ~altOpenDrain)) == $past(altOwns & ~altOpenDrain));
  endproperty
  a_altPushPull: assert property (p_altPushPull)
    else $error("peripheral push-pull output not driven");

  property p_readOutputLatch;
    (rdPend_reg && hitData && dir_reg == 8'hFF) |=> (hrdata[7:0] == $past(latch_reg));
  endproperty
  a_readOutputLatch: assert property (p_readOutputLatch)
    else $error("output read did not return the latch");

  property p_altInLatch;
    1'b1 |=> ((altIn & $past(dir_reg)) == ($past(latch_reg) & $past(dir_reg)));
  endproperty
  a_altInLatch: assert property (p_altInLatch)
    else $error("peripheral input did not see latch on output pin");

  property p_irqCover;
    eventAny ##1 irqReq;
  endproperty
  c_irqCover: cover property (p_irqCover);

  property p_readCover;
    rdPend_reg ##1 hreadyout;
  endproperty
  c_readCover: cover property (p_readCover);

  property p_altCover;
    (altOwns != 8'h00) ##1 (pinOe != 8'h00);
  endproperty
  c_altCover: cover property (p_altCover);

endmodule
`default_nettype wire

// [design/gpx_cfg.svh]
// register offsets, reset values and pin capability defaults of the gpio port
`ifndef GPX_CFG_SVH
`define GPX_CFG_SVH

// ==========================================================================
// register map (byte addresses, one aligned word each)
`define GPX_OFF_DATA 12'h000
`define GPX_OFF_DIR 12'h004
`define GPX_OFF_CFG 12'h008
`define GPX_OFF_SENSE 12'h00C
`define GPX_OFF_LEVEL 12'h010

// ==========================================================================
// reset values and bus constants
`define GPX_RST_PORT 8'h00
`define GPX_RST_SENSE 2'h0
`define GPX_RST_WORD 32'h0000_0000
`define GPX_HSIZE_WORD 3'h2

// ==========================================================================
// pin capability defaults: interrupt-capable and pull-up-capable pins
`define GPX_IRQ_PINS_DEF 8'h08
`define GPX_PULL_PINS_DEF 8'hF7

`endif

// [design/gpx_pkg.sv]
// types shared by the gpio port design
package gpx_pkg;

  // ========================================================================
  // external interrupt sensitivity, in register encoding order
  typedef enum logic [1:0]
  {
    GPX_SENSE_LOW,
    GPX_SENSE_RISE,
    GPX_SENSE_FALL,
    GPX_SENSE_BOTH
  } gpx_sense_type;

endpackage

// [design/gpx_sync.sv]
// three-stage pin input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module gpx_sync
  import gpx_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // ========================================================================
  // synchroniser stages
  logic [WIDTH-1:0] stage1Reg;
  logic [WIDTH-1:0] stage2Reg;
  logic [WIDTH-1:0] stage3Reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;
  logic [WIDTH-1:0] agree;

  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("gpx_sync: WIDTH must be at least 1");
    end
  endgenerate

  // a change only counts once stages two and three agree, so a sample caught
  // mid-transition never reaches the edge detector
  assign agree = ~(stage2Reg ^ stage3Reg);
  assign level_next = (agree & stage3Reg) | (~agree & level_reg);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      stage1Reg <= '0;
      stage2Reg <= '0;
      stage3Reg <= '0;
      level_reg <= '0;
    end
    else
    begin
      stage1Reg <= asyncIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
      level_reg <= level_next;
    end
  end

  assign syncOut = level_reg;

endmodule
`default_nettype wire

// [verif/gpx_pin_model.sv]
// external pad model: resolves each pin from port drive, outside driver and pull-up
`timescale 1ns/10ps
`default_nettype none

module gpx_pin_model
(
  input wire logic ref_clk,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] pullUpEn,
  input wire logic [7:0] extEn,
  input wire logic [7:0] extLvl,
  output logic [7:0] pinIn
);
  logic [7:0] floatReg = 8'h55;

  // ==========================================================================
  // pad resolution
  // a pad nobody drives wanders, so it toggles every cycle rather than hold
  always_ff @(posedge ref_clk)
  begin
    floatReg <= ~floatReg;
  end

  // port drive wins over the outside driver wherever both drive a pin
  assign pinIn = (pinOe & pinOut)
    | (~pinOe & ((extEn & extLvl) | (~extEn & (pullUpEn | floatReg))));
endmodule

`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the gpio port
`timescale 1ns/10ps
`default_nettype none

`include "gpx_cfg.svh"

module tb_top
  import gpx_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irqReq, wakeReq, ex;
  logic [31:0] hrdata, rdData;
  logic [7:0] pinIn, pinOut, pinOe, pullUpEn, altIn;
  logic [7:0] altEnable = 8'h00, altOutEn = 8'h00, altOut = 8'h00, altOpenDrain = 8'h00;
  logic [7:0] extEn = 8'hFF, extLvl = 8'h00, p;
  logic cpuIrqMask = 1'b0, vectorFetch = 1'b0;
  logic [71:0] row;
  int numErrors = 0, nTests = 0;
  // dir cfg latch extEn extLvl | pinOe drive pullUp read
  logic [71:0] rows [5] = '{72'h0000A5FF3D0000003D, 72'h00FF0009090000F6FF,
    72'hFFFF5A0000FF5A005A, 72'hFF005A0000A500005A, 72'h0FF033F0900C00F093};

  // ==========================================================================
  // device and pads
  gpx_port #(.IRQ_PINS(8'h09), .PULL_PINS(8'hF6)) uut (.ref_clk(ref_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn),
    .altEnable(altEnable), .altOutEn(altOutEn), .altOut(altOut),
    .altOpenDrain(altOpenDrain), .altIn(altIn), .cpuIrqMask(cpuIrqMask),
    .vectorFetch(vectorFetch), .irqReq(irqReq), .wakeReq(wakeReq));

  gpx_pin_model pads (.ref_clk(ref_clk), .pinOut(pinOut), .pinOe(pinOe),
    .pullUpEn(pullUpEn), .extEn(extEn), .extLvl(extLvl), .pinIn(pinIn));

  always #4 ref_clk = ~ref_clk;

  // ==========================================================================
  // tasks
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task waitRdy;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
  endtask

  // one single transfer; the watchdog bounds every wait
  task bus(input logic wr, input logic [2:0] sz, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= sz;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy();
    rdData = hrdata;
  endtask

  task w(input logic [11:0] a, input logic [7:0] v);
    bus(1'b1, 3'h2, a, {24'h0, v});
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task endSim;
    $display("checks %0d errors %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // outputs other than pinOut, and every register, back at their reset values after a release
  task resetChk;
    tick(4);
    chk("reset outs", {4'h0, pinOe, pullUpEn, altIn, irqReq, wakeReq, hresp, hreadyout}, 32'h1);
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, 3'h2, 12'(i * 4), 32'h0);
      chk("reset reg", rdData, 32'h0);
    end
  endtask

  initial
  begin
    #(8 * 20000);
    numErrors++;
    endSim();
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    tick(20);
    rst <= 1'b0;
    resetChk();
    w(12'h020, 8'hFF);
    bus(1'b0, 3'h2, 12'h020, 32'h0);
    chk("unmapped", rdData, 32'h0);
    bus(1'b1, 3'h0, `GPX_OFF_DIR, 32'hFF);
    bus(1'b0, 3'h2, `GPX_OFF_DIR, 32'h0);
    chk("byte write", {rdData[31:1], hresp}, 32'h0);
    foreach (rows[i])
    begin
      row = rows[i];
      w(`GPX_OFF_DATA, row[55:48]);
      w(`GPX_OFF_DIR, row[71:64]);
      w(`GPX_OFF_CFG, row[63:56]);
      extEn <= row[47:40];
      extLvl <= row[39:32];
      tick(8);
      chk("pinOe", {24'h0, pinOe}, {24'h0, row[31:24]});
      chk("drive", {24'h0, pinOut & pinOe}, {24'h0, row[23:16]});
      chk("pullUp", {24'h0, pullUpEn}, {24'h0, row[15:8]});
      bus(1'b0, 3'h2, `GPX_OFF_DATA, 32'h0);
      chk("data read", rdData, {24'h0, row[7:0]});
    end
    w(`GPX_OFF_DIR, 8'h00);
    extEn <= 8'hFF;
    extLvl <= 8'hFF;
    w(`GPX_OFF_CFG, 8'h09);
    tick(8);
    for (int m = 0; m < 4; m++)
    begin
      p = (m % 2 == 1) ? 8'h01 : 8'h08;
      cpuIrqMask <= (m == 3);
      w(`GPX_OFF_SENSE, 8'(m));
      tick(2);
      chk("cancel", {31'h0, wakeReq}, 32'h0);
      extLvl <= ~p;
      tick(8);
      ex = (m != 1);
      chk("fall", {30'h0, irqReq, wakeReq}, {30'h0, ex & (m != 3), ex});
      vectorFetch <= 1'b1;
      tick(1);
      vectorFetch <= 1'b0;
      tick(3);
      chk("fetch", {31'h0, wakeReq}, {31'h0, m == 0});
      extLvl <= 8'hFF;
      tick(8);
      chk("rise", {31'h0, wakeReq}, {31'h0, m != 2});
    end
    bus(1'b0, 3'h2, `GPX_OFF_SENSE, 32'h0);
    chk("sense read", rdData, 32'h3);
    bus(1'b0, 3'h2, `GPX_OFF_LEVEL, 32'h0);
    chk("level read", rdData, 32'hFF);
    w(`GPX_OFF_SENSE, 8'h00);
    tick(2);
    chk("cancel end", {31'h0, wakeReq}, 32'h0);
    w(`GPX_OFF_CFG, 8'h00);
    w(`GPX_OFF_DATA, 8'h02);
    w(`GPX_OFF_DIR, 8'h02);
    w(`GPX_OFF_CFG, 8'h02);
    extLvl <= 8'hFE;
    altEnable <= 8'h03;
    altOutEn <= 8'h01;
    altOut <= 8'h01;
    altOpenDrain <= 8'h01;
    tick(4);
    chk("alt od", {28'h0, pinOe[1:0], pinOut[1:0] & pinOe[1:0]}, 32'hA);
    chk("alt in", {31'h0, altIn[1]}, 32'h1);
    bus(1'b0, 3'h2, `GPX_OFF_DATA, 32'h0);
    chk("alt read", {30'h0, rdData[1:0]}, 32'h3);
    altOut <= 8'h00;
    altOpenDrain <= 8'h00;
    w(`GPX_OFF_DATA, 8'h00);
    tick(4);
    chk("alt pp", {28'h0, pinOe[1:0], pinOut[1:0]}, 32'hC);
    chk("alt in low", {31'h0, altIn[1]}, 32'h0);
    bus(1'b0, 3'h2, `GPX_OFF_DATA, 32'h0);
    chk("alt read low", {30'h0, rdData[1:0]}, 32'h0);
    // mid-run reset; the peripheral claim is dropped first so no pin is owned
    // at the release edge, and the pins are held low so the synchroniser stays quiet
    rst <= 1'b1;
    altEnable <= 8'h00;
    extLvl <= 8'h00;
    tick(4);
    rst <= 1'b0;
    resetChk();
    endSim();
  end
endmodule

`default_nettype wire
